// ===== tmc_pkg.sv
`default_nettype none
// Shared constants for the second timer/counter register block.
package tmc_pkg;

    // I/O addresses of the registers on the 8-bit data bus.
    localparam logic [5:0] ADDR_COMPARE_B = 6'h21;
    localparam logic [5:0] ADDR_COMPARE_A = 6'h22;
    localparam logic [5:0] ADDR_COUNT_LO = 6'h23;
    localparam logic [5:0] ADDR_FLAGS = 6'h25;
    localparam logic [5:0] ADDR_ENABLES = 6'h26;
    localparam logic [5:0] ADDR_COUNT_HI = 6'h27;

    // Bit positions shared by the enable and flag registers.
    localparam int BIT_CAPTURE = 7;
    localparam int BIT_RESERVED = 6;
    localparam int BIT_COMPARE_B = 5;
    localparam int BIT_COMPARE_A = 4;
    localparam int BIT_OVERFLOW = 3;

    // Reset value of every byte register and of the counter.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_COUNT = 16'h0000;

    // Writable bits of the enable register; bit 6 always reads zero.
    localparam logic [7:0] ENABLES_WRITABLE = 8'hbf;

    // Flag bits with timer behaviour, and the stored low flag bits.
    localparam logic [7:0] FLAGS_TIMER = 8'hb8;
    localparam logic [7:0] FLAGS_LOOSE = 8'h07;

    // Largest counter values in 8-bit and 16-bit width.
    localparam logic [7:0] COUNT_MAX_NARROW = 8'hff;
    localparam logic [15:0] COUNT_MAX_WIDE = 16'hffff;

    // Answer for a read of an address outside this block.
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

endpackage
`default_nettype wire

// ===== tmc_match.sv
`timescale 1ns/1ps
`default_nettype none
// Compare, overflow and TOP detection for the counter.
module tmc_match (
    input wire logic [15:0] count,    // Present counter value.
    input wire logic [7:0] cmp_a,     // Compare A byte.
    input wire logic [7:0] cmp_b,     // Compare B byte.
    input wire logic wide,            // Counter width select.
    input wire logic capture_mode,    // Input capture mode enable.
    input wire logic capture_as_top,  // Capture register serves as TOP.
    output logic match_a,             // Compare A match.
    output logic match_b,             // Compare B match.
    output logic at_max,              // Counter at its largest value.
    output logic at_top               // Counter at capture TOP.
);

    // Matches are judged on the count held when the timer clock arrives.
    always_comb begin
        at_top = capture_as_top && (count == {cmp_b, cmp_a});
        if (wide) begin
            at_max = (count == tmc_pkg::COUNT_MAX_WIDE);
            // Compare B is the high byte of one compare value.
            match_a = !capture_mode && (count == {cmp_b, cmp_a});
            match_b = 1'b0;
        end else begin
            at_max = (count[7:0] == tmc_pkg::COUNT_MAX_NARROW);
            match_a = !capture_mode && (count[7:0] == cmp_a);
            match_b = !capture_mode && (count[7:0] == cmp_b);
        end
    end

endmodule
`default_nettype wire

// ===== tmc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_timer (
    input wire logic core_clk,             // System clock, 100 MHz.
    input wire logic rst_n,                // Asynchronous reset, low.
    input wire logic [5:0] io_addr,        // I/O register address.
    input wire logic [7:0] io_wdata,       // Write data.
    input wire logic io_we,                // Write strobe, one cycle.
    input wire logic io_re,                // Read strobe, one cycle.
    output logic [7:0] io_rdata,           // Read data, next cycle.
    input wire logic timer_tick,           // Timer clock enable pulse.
    input wire logic counter_width_select, // High selects 16-bit mode.
    input wire logic capture_mode,         // Input capture mode enable.
    input wire logic capture_as_top,       // Capture register is TOP.
    input wire logic capture_event,        // Capture pin event pulse.
    input wire logic [2:0] loose_flag_set, // Set pulses, flag bits 2..0.
    input wire logic global_irq_enable,    // CPU global enable bit.
    input wire logic capture_ack,          // Capture vector taken.
    input wire logic compare_a_ack,        // Compare A vector taken.
    input wire logic compare_b_ack,        // Compare B vector taken.
    input wire logic overflow_ack,         // Overflow vector taken.
    output logic capture_irq,              // Capture request.
    output logic compare_a_irq,            // Compare A request.
    output logic compare_b_irq,            // Compare B request.
    output logic overflow_irq,             // Overflow request.
    output logic [15:0] counter_value      // Counter, from register.
);

    // Every flip-flop of the block lives in this one record.
    typedef struct packed {
        logic [15:0] count;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [7:0] temp;
        logic [7:0] enables;
        logic [7:0] flags;
        logic block_match;
        logic [7:0] rdata;
    } tmc_state_t;

    // Present state and the value it takes at the next edge.
    tmc_state_t s;
    tmc_state_t next_s;

    // Results of the compare unit.
    logic match_a;
    logic match_b;
    logic at_max;
    logic at_top;

    // Mode shorthands and the counter plus one in either width.
    logic wide;
    logic wide_capture;
    logic [15:0] count_plus_one;
    logic [7:0] low_plus_one;

    // Per-bit flag set and clear requests.
    logic [7:0] flag_set;
    logic [7:0] flag_clear;
    logic [7:0] write_clear;

    // Bus strobes qualified by this block's address range.
    logic rd_hit;
    logic wr_hit;

    // One request per interrupt source, in descending flag bit order: capture, compare B, compare A, overflow.
    logic [3:0] irq_req;

    // Shorthands for the two modes that change register access.
    assign wide = counter_width_select;
    assign wide_capture = counter_width_select && capture_mode;

    // The counter plus one; the narrow form wraps inside the low byte.
    assign count_plus_one = s.count + 16'h0001;
    assign low_plus_one = s.count[7:0] + 8'h01;

    // The compare unit looks at the registered count and compare bytes.
    tmc_match u_match (
        .count(s.count),
        .cmp_a(s.cmp_a),
        .cmp_b(s.cmp_b),
        .wide(wide),
        .capture_mode(capture_mode),
        .capture_as_top(capture_as_top),
        .match_a(match_a),
        .match_b(match_b),
        .at_max(at_max),
        .at_top(at_top)
    );

    // Hardware events that set a flag, gathered per bit position.
    always_comb begin
        flag_set = tmc_pkg::RESET_BYTE;
        if (timer_tick) begin
            // A counter write just before this tick hides the match.
            if (!s.block_match) begin
                flag_set[tmc_pkg::BIT_COMPARE_A] = match_a;
                flag_set[tmc_pkg::BIT_COMPARE_B] = match_b;
            end
            flag_set[tmc_pkg::BIT_OVERFLOW] = at_max && !at_top;
            flag_set[tmc_pkg::BIT_CAPTURE] = at_top;
        end
        if (capture_mode && capture_event) begin
            flag_set[tmc_pkg::BIT_CAPTURE] = 1'b1;
        end
        // Low flag bits follow their own set pulses.
        flag_set[2:0] = loose_flag_set;
    end

    // Sources that clear a flag: a vector acknowledge or a written one.
    always_comb begin
        write_clear = tmc_pkg::RESET_BYTE;
        if (io_we && io_addr == tmc_pkg::ADDR_FLAGS) begin
            // Zero bits in the written byte leave their flag alone.
            write_clear = io_wdata & (tmc_pkg::FLAGS_TIMER |
                tmc_pkg::FLAGS_LOOSE);
        end
        flag_clear = write_clear;
        flag_clear[tmc_pkg::BIT_CAPTURE] =
            write_clear[tmc_pkg::BIT_CAPTURE] || capture_ack;
        flag_clear[tmc_pkg::BIT_COMPARE_A] =
            write_clear[tmc_pkg::BIT_COMPARE_A] || compare_a_ack;
        flag_clear[tmc_pkg::BIT_COMPARE_B] =
            write_clear[tmc_pkg::BIT_COMPARE_B] || compare_b_ack;
        flag_clear[tmc_pkg::BIT_OVERFLOW] =
            write_clear[tmc_pkg::BIT_OVERFLOW] || overflow_ack;
    end

    // Decode flags telling whether the address belongs to this block.
    always_comb begin
        case (io_addr)
            tmc_pkg::ADDR_COMPARE_B,
            tmc_pkg::ADDR_COMPARE_A,
            tmc_pkg::ADDR_COUNT_LO,
            tmc_pkg::ADDR_FLAGS,
            tmc_pkg::ADDR_ENABLES,
            tmc_pkg::ADDR_COUNT_HI: begin
                rd_hit = io_re;
                wr_hit = io_we;
            end
            default: begin
                rd_hit = 1'b0;
                wr_hit = 1'b0;
            end
        endcase
    end

    // Next state: counting first, then captures, flags and bus access.
    always_comb begin
        next_s = s;

        // Counting on the timer clock enable.
        if (timer_tick) begin
            next_s.block_match = 1'b0;
            if (at_top) begin
                // The capture register acts as TOP and restarts the count.
                next_s.count = tmc_pkg::RESET_COUNT;
            end else if (wide) begin
                next_s.count = count_plus_one;
            end else begin
                // Narrow mode counts in the low byte only and wraps there.
                next_s.count[7:0] = low_plus_one;
            end
        end

        // A capture copies the full count into the compare pair.
        if (capture_mode && capture_event) begin
            next_s.cmp_b = s.count[15:8];
            next_s.cmp_a = s.count[7:0];
        end

        // Set beats clear, so an event in a clearing cycle is kept.
        next_s.flags = (s.flags & ~flag_clear) | flag_set;
        next_s.flags[tmc_pkg::BIT_RESERVED] = 1'b0;

        // Register writes from the CPU.
        if (wr_hit) begin
            case (io_addr)
                // Counter low byte: direct, or commits the latched byte.
                tmc_pkg::ADDR_COUNT_LO: begin
                    if (wide) begin
                        // Both counter bytes land together.
                        next_s.count = {s.temp, io_wdata};
                    end else begin
                        next_s.count[7:0] = io_wdata;
                    end
                    next_s.block_match = 1'b1;
                end
                // Counter high byte: latched in wide mode, else direct.
                tmc_pkg::ADDR_COUNT_HI: begin
                    if (wide) begin
                        next_s.temp = io_wdata;
                    end else begin
                        next_s.count[15:8] = io_wdata;
                    end
                end
                // Compare A: in wide mode it also commits compare B.
                tmc_pkg::ADDR_COMPARE_A: begin
                    if (wide) begin
                        // The low byte write commits the latched high byte.
                        next_s.cmp_a = io_wdata;
                        next_s.cmp_b = s.temp;
                    end else begin
                        next_s.cmp_a = io_wdata;
                    end
                end
                // Compare B: latched in wide mode, direct otherwise.
                tmc_pkg::ADDR_COMPARE_B: begin
                    if (wide) begin
                        next_s.temp = io_wdata;
                    end else begin
                        next_s.cmp_b = io_wdata;
                    end
                end
                // Enable register: the reserved bit is never stored.
                tmc_pkg::ADDR_ENABLES: begin
                    next_s.enables = io_wdata &
                        tmc_pkg::ENABLES_WRITABLE;
                end
                // The flag register is handled with the other flag sources.
                default: begin
                    next_s.enables = s.enables;
                end
            endcase
        end

        // Register reads, answered one cycle after the strobe.
        if (io_re) begin
            next_s.rdata = tmc_pkg::UNMAPPED_DATA;
        end
        if (rd_hit) begin
            case (io_addr)
                // Counter low byte; a wide read freezes the high byte.
                tmc_pkg::ADDR_COUNT_LO: begin
                    next_s.rdata = s.count[7:0];
                    if (wide) begin
                        // Reading the low byte freezes the high byte.
                        next_s.temp = s.count[15:8];
                    end
                end
                // Counter high byte, from the latch in wide mode.
                tmc_pkg::ADDR_COUNT_HI: begin
                    if (wide) begin
                        next_s.rdata = s.temp;
                    end else begin
                        next_s.rdata = s.count[15:8];
                    end
                end
                // Compare A; in wide capture mode it freezes compare B.
                tmc_pkg::ADDR_COMPARE_A: begin
                    next_s.rdata = s.cmp_a;
                    if (wide_capture) begin
                        next_s.temp = s.cmp_b;
                    end
                end
                // Compare B, from the latch only in wide capture mode.
                tmc_pkg::ADDR_COMPARE_B: begin
                    if (wide_capture) begin
                        next_s.rdata = s.temp;
                    end else begin
                        next_s.rdata = s.cmp_b;
                    end
                end
                // Flags, with the reserved bit held at zero.
                tmc_pkg::ADDR_FLAGS: begin
                    next_s.rdata = s.flags;
                end
                // Enables, with the reserved bit never stored.
                tmc_pkg::ADDR_ENABLES: begin
                    next_s.rdata = s.enables;
                end
                // No other address reaches this case.
                default: begin
                    next_s.rdata = tmc_pkg::UNMAPPED_DATA;
                end
            endcase
        end
    end

    // State register; reset loads constants only.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s.count <= tmc_pkg::RESET_COUNT;
            s.cmp_a <= tmc_pkg::RESET_BYTE;
            s.cmp_b <= tmc_pkg::RESET_BYTE;
            s.temp <= tmc_pkg::RESET_BYTE;
            s.enables <= tmc_pkg::RESET_BYTE;
            s.flags <= tmc_pkg::RESET_BYTE;
            s.block_match <= 1'b0;
            s.rdata <= tmc_pkg::RESET_BYTE;
        end else begin
            // Out of reset every field follows its next value.
            s <= next_s;
        end
    end

    // Flag and enable bit of each interrupt source, in descending bit order: capture, compare B, compare A, overflow.
    localparam int SRC_BIT [4] = '{tmc_pkg::BIT_CAPTURE,
        tmc_pkg::BIT_COMPARE_B, tmc_pkg::BIT_COMPARE_A,
        tmc_pkg::BIT_OVERFLOW};

    // A request needs its flag, its enable and the global enable.
    for (genvar i = 0; i < 4; i++) begin : g_irq
        assign irq_req[i] = global_irq_enable &&
            s.enables[SRC_BIT[i]] && s.flags[SRC_BIT[i]];
    end

    // Each request output is one entry of the loop above.
    assign capture_irq = irq_req[0];
    assign compare_b_irq = irq_req[1];
    assign compare_a_irq = irq_req[2];
    assign overflow_irq = irq_req[3];

    // Registered outputs.
    assign io_rdata = s.rdata;
    assign counter_value = s.count;

endmodule
`default_nettype wire

// ===== tmc_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of counting, flag setting, clearing and read data.
module tmc_timer_sva (
    input wire logic core_clk,             // System clock.
    input wire logic rst_n,                // Asynchronous reset, low.
    input wire logic [5:0] io_addr,        // Register address.
    input wire logic [7:0] io_wdata,       // Write data.
    input wire logic io_we,                // Write strobe.
    input wire logic io_re,                // Read strobe.
    input wire logic [7:0] io_rdata,       // Read data.
    input wire logic timer_tick,           // Count enable.
    input wire logic counter_width_select, // Wide mode.
    input wire logic capture_mode,         // Capture mode.
    input wire logic capture_as_top,       // Capture is TOP.
    input wire logic capture_event,        // Capture pulse.
    input wire logic [2:0] loose_flag_set, // Low flag sets.
    input wire logic global_irq_enable,    // Global enable.
    input wire logic capture_ack,          // Capture taken.
    input wire logic compare_a_ack,        // Compare A taken.
    input wire logic compare_b_ack,        // Compare B taken.
    input wire logic overflow_ack,         // Overflow taken.
    input wire logic capture_irq,          // Capture request.
    input wire logic compare_a_irq,        // Compare A request.
    input wire logic compare_b_irq,        // Compare B request.
    input wire logic overflow_irq,         // Overflow request.
    input wire logic [15:0] counter_value  // Counter.
);
    // All checks share the one clock and its reset.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    narrow_count_a: assert property (timer_tick && !io_we &&
        !counter_width_select && !capture_as_top |=> counter_value ==
        {$past(counter_value[15:8]), $past(counter_value[7:0]) + 8'h01})
        else $error("narrow count step wrong");
    wide_count_a: assert property (timer_tick && !io_we &&
        counter_width_select && !capture_as_top |=>
        counter_value == $past(counter_value) + 16'h0001)
        else $error("wide count step wrong");
    irq_gate_a: assert property ((capture_irq || compare_a_irq ||
        compare_b_irq || overflow_irq) |-> global_irq_enable)
        else $error("request without global enable");
    cmp_a_set_a: assert property ($rose(compare_a_irq) &&
        $stable(global_irq_enable) && !$past(io_we)
        |-> $past(timer_tick && !capture_mode))
        else $error("compare A set without match tick");
    cmp_b_set_a: assert property ($rose(compare_b_irq) &&
        $stable(global_irq_enable) && !$past(io_we) |->
        $past(timer_tick && !counter_width_select && !capture_mode))
        else $error("compare B set outside narrow mode");
    ovf_set_a: assert property ($rose(overflow_irq) &&
        $stable(global_irq_enable) && !$past(io_we) |->
        $past(timer_tick) && $past(counter_value[7:0]) == 8'hff)
        else $error("overflow set away from wrap");
    cap_ack_a: assert property (capture_ack && !capture_event &&
        !timer_tick |=> !capture_irq)
        else $error("capture ack did not clear");
    cmpa_ack_a: assert property (compare_a_ack && !timer_tick
        |=> !compare_a_irq) else $error("compare A ack did not clear");
    cmpb_ack_a: assert property (compare_b_ack && !timer_tick
        |=> !compare_b_irq) else $error("compare B ack did not clear");
    ovf_ack_a: assert property (overflow_ack && !timer_tick
        |=> !overflow_irq) else $error("overflow ack did not clear");
    reserved_bit_a: assert property (io_re &&
        (io_addr == tmc_pkg::ADDR_FLAGS ||
        io_addr == tmc_pkg::ADDR_ENABLES) |=> !io_rdata[6])
        else $error("reserved bit read as one");
endmodule

bind tmc_timer tmc_timer_sva u_sva (
    .core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
    .io_rdata(io_rdata), .timer_tick(timer_tick),
    .counter_width_select(counter_width_select),
    .capture_mode(capture_mode), .capture_as_top(capture_as_top),
    .capture_event(capture_event), .loose_flag_set(loose_flag_set),
    .global_irq_enable(global_irq_enable), .capture_ack(capture_ack),
    .compare_a_ack(compare_a_ack), .compare_b_ack(compare_b_ack),
    .overflow_ack(overflow_ack), .capture_irq(capture_irq),
    .compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq),
    .overflow_irq(overflow_irq), .counter_value(counter_value)
);
`default_nettype wire

// ===== test_timer1_counter_compare_flags.sv
`timescale 1ns/1ps
`default_nettype none
// Directed bench for the timer register block.
module test_timer1_counter_compare_flags;
    logic core_clk, rst_n, io_we, io_re, timer_tick, wide, cap_mode;
    logic cap_top, cap_ev, gie, cap_ack, a_ack, b_ack, ovf_ack;
    logic cap_irq, a_irq, b_irq, ovf_irq;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata;
    logic [2:0] loose;
    logic [15:0] cnt;
    int err_count, num_checks;

    tmc_timer u_dut (.core_clk(core_clk), .rst_n(rst_n),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
        .io_re(io_re), .io_rdata(io_rdata), .timer_tick(timer_tick),
        .counter_width_select(wide), .capture_mode(cap_mode),
        .capture_as_top(cap_top), .capture_event(cap_ev),
        .loose_flag_set(loose), .global_irq_enable(gie),
        .capture_ack(cap_ack), .compare_a_ack(a_ack),
        .compare_b_ack(b_ack), .overflow_ack(ovf_ack),
        .capture_irq(cap_irq), .compare_a_irq(a_irq),
        .compare_b_irq(b_irq), .overflow_irq(ovf_irq),
        .counter_value(cnt));

    // Free-running clock at 100 MHz.
    always #5 core_clk = ~core_clk;

    task automatic chk(input string what, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        io_addr = a;
        io_wdata = d;
        io_we = 1'b1;
        @(negedge core_clk);
        io_we = 1'b0;
    endtask

    // Read data is registered at the taking edge.
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(negedge core_clk);
        io_addr = a;
        io_re = 1'b1;
        @(negedge core_clk);
        io_re = 1'b0;
        chk("io_rdata", {8'h00, io_rdata}, {8'h00, e});
    endtask

    task automatic tick();
        @(negedge core_clk);
        timer_tick = 1'b1;
        @(negedge core_clk);
        timer_tick = 1'b0;
    endtask

    task automatic test_regs();
        logic [5:0] map [7];
        map = '{6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27};
        foreach (map[i]) rd(map[i], tmc_pkg::RESET_BYTE);
        wr(tmc_pkg::ADDR_ENABLES, 8'hff);
        rd(tmc_pkg::ADDR_ENABLES, tmc_pkg::ENABLES_WRITABLE);
        @(negedge core_clk);
        loose = 3'h5;
        @(negedge core_clk);
        loose = 3'h0;
        rd(tmc_pkg::ADDR_FLAGS, 8'h05);
        wr(tmc_pkg::ADDR_FLAGS, 8'h07);
        rd(tmc_pkg::ADDR_FLAGS, 8'h00);
        $display("test_regs done");
    endtask

    task automatic test_narrow();
        wr(tmc_pkg::ADDR_ENABLES, 8'h30);
        wr(tmc_pkg::ADDR_COMPARE_A, 8'h11);
        wr(tmc_pkg::ADDR_COMPARE_B, 8'h11);
        wr(tmc_pkg::ADDR_COUNT_LO, 8'h11);
        tick();
        rd(tmc_pkg::ADDR_FLAGS, 8'h00);
        wr(tmc_pkg::ADDR_COUNT_LO, 8'h10);
        tick();
        tick();
        rd(tmc_pkg::ADDR_FLAGS, 8'h30);
        chk("irq_ab", {a_irq, b_irq}, 16'h0003);
        gie = 1'b0;
        #1 chk("irq_gated", {a_irq, b_irq}, 16'h0000);
        @(negedge core_clk);
        gie = 1'b1;
        b_ack = 1'b1;
        @(negedge core_clk);
        b_ack = 1'b0;
        wr(tmc_pkg::ADDR_FLAGS, 8'h00);
        rd(tmc_pkg::ADDR_FLAGS, 8'h10);
        wr(tmc_pkg::ADDR_COUNT_LO, 8'h10);
        tick();
        tick();
        wr(tmc_pkg::ADDR_FLAGS, 8'h20);
        rd(tmc_pkg::ADDR_FLAGS, 8'h10);
        @(negedge core_clk);
        a_ack = 1'b1;
        @(negedge core_clk);
        a_ack = 1'b0;
        rd(tmc_pkg::ADDR_FLAGS, 8'h00);
        $display("test_narrow done");
    endtask

    task automatic test_overflow();
        wr(tmc_pkg::ADDR_ENABLES, 8'h08);
        wr(tmc_pkg::ADDR_COUNT_HI, 8'h55);
        wr(tmc_pkg::ADDR_COUNT_LO, 8'hfe);
        tick();
        tick();
        chk("count", cnt, 16'h5500);
        chk("ovf_irq", {15'h0, ovf_irq}, 16'h0001);
        @(negedge core_clk);
        ovf_ack = 1'b1;
        @(negedge core_clk);
        ovf_ack = 1'b0;
        rd(tmc_pkg::ADDR_FLAGS, 8'h00);
        $display("test_overflow done");
    endtask

    task automatic test_wide();
        wide = 1'b1;
        wr(tmc_pkg::ADDR_COUNT_HI, 8'h01);
        wr(tmc_pkg::ADDR_COUNT_LO, 8'hff);
        chk("count", cnt, 16'h01ff);
        rd(tmc_pkg::ADDR_COUNT_LO, 8'hff);
        rd(tmc_pkg::ADDR_COUNT_HI, 8'h01);
        wr(tmc_pkg::ADDR_COMPARE_B, 8'h02);
        wr(tmc_pkg::ADDR_COMPARE_A, 8'h01);
        // A lone high write parks another byte in the latch.
        wr(tmc_pkg::ADDR_COUNT_HI, 8'h07);
        rd(tmc_pkg::ADDR_COMPARE_B, 8'h02);
        rd(tmc_pkg::ADDR_COMPARE_A, 8'h01);
        tick();
        tick();
        tick();
        rd(tmc_pkg::ADDR_FLAGS, 8'h10);
        wr(tmc_pkg::ADDR_FLAGS, 8'h10);
        rd(tmc_pkg::ADDR_FLAGS, 8'h00);
        $display("test_wide done");
    endtask

    task automatic test_capture();
        wr(tmc_pkg::ADDR_ENABLES, 8'h80);
        wr(tmc_pkg::ADDR_COUNT_HI, 8'h12);
        wr(tmc_pkg::ADDR_COUNT_LO, 8'h34);
        cap_mode = 1'b1;
        @(negedge core_clk);
        cap_ev = 1'b1;
        @(negedge core_clk);
        cap_ev = 1'b0;
        chk("cap_irq", {15'h0, cap_irq}, 16'h0001);
        rd(tmc_pkg::ADDR_COMPARE_A, 8'h34);
        rd(tmc_pkg::ADDR_COMPARE_B, 8'h12);
        wr(tmc_pkg::ADDR_FLAGS, 8'h80);
        rd(tmc_pkg::ADDR_FLAGS, 8'h00);
        cap_top = 1'b1;
        tick();
        chk("count", cnt, 16'h0000);
        rd(tmc_pkg::ADDR_FLAGS, 8'h80);
        @(negedge core_clk);
        cap_ack = 1'b1;
        @(negedge core_clk);
        cap_ack = 1'b0;
        rd(tmc_pkg::ADDR_FLAGS, 8'h00);
        $display("test_capture done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Reset, then the scenarios in order.
    initial begin
        {core_clk, rst_n, io_we, io_re, timer_tick, wide, cap_mode} = '0;
        {cap_top, cap_ev, cap_ack, a_ack, b_ack, ovf_ack} = '0;
        {io_addr, io_wdata, loose} = '0;
        gie = 1'b1;
        err_count = 0;
        num_checks = 0;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        test_regs();
        test_narrow();
        test_overflow();
        test_wide();
        test_capture();
        complete_run();
    end

    // Cuts a hang short well beyond the expected run.
    initial begin
        #20000;
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire
